// *** bench/swsc_monitor.sv ***
// Line-level checks; watches only the shared wire and its drivers
module swsc_monitor #(
	parameter int PUP_CYC  = 1500, // Power-up wait, longer than the device's own power-up presence
	parameter int RSTL_CYC = 4500, // Reset low
	parameter int RESET_HIGH_INTERVAL_CYC = 1200  // Reset high interval
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Line drivers and level
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic mst_out,
	input wire logic mst_oe,
	input wire logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [19:0] hi_run, lo_run, oe_run, m_run, m_gap, m_per, up_cnt, last_lo, last_m; // Run lengths
	logic        pup, m_go; // Still in power-up; master has started
	// Run counters; 20 bits outlast the whole run, so no saturation needed
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{hi_run, lo_run, oe_run, m_run, m_gap, m_per, up_cnt, last_lo, last_m} <= '0;
			pup <= 1'b1;
			m_go <= 1'b0;
		end else begin
			hi_run <= line ? hi_run + 20'h1 : 20'h0;
			lo_run <= line ? 20'h0 : lo_run + 20'h1;
			oe_run <= dev_oe ? oe_run + 20'h1 : 20'h0;
			m_run <= mst_oe ? m_run + 20'h1 : 20'h0;
			m_gap <= mst_oe ? 20'h0 : m_gap + 20'h1;
			m_per <= (mst_oe && m_run == 20'h0) ? 20'h1 : m_per + 20'h1;
			up_cnt <= up_cnt + 20'h1;
			last_lo <= (line && lo_run != 20'h0) ? lo_run : last_lo;
			last_m <= (!mst_oe && m_run != 20'h0) ? m_run : last_m;
			pup <= pup && !mst_oe;
			m_go <= m_go || mst_oe;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	open_drain_a: assert property ((dev_oe |-> !dev_out) and (mst_oe |-> !mst_out))
		else $error("line driven high");
	pres_place_a: assert property ($rose(dev_oe) && $past(line) |->
		(pup || last_lo >= 20'd4000) && hi_run inside {[20'd190:20'd215]}) else $error("presence misplaced");
	pulse_len_a: assert property ($fell(dev_oe) |-> oe_run inside {[20'd290:20'd305], [20'd799:20'd803]})
		else $error("device pulse length wrong");
	pup_2ms_a: assert property (dev_oe && pup |-> up_cnt < 20'd200000)
		else $error("power-up presence too late");
	read_sync_a: assert property ($rose(dev_oe) && !$past(line) |-> mst_oe && lo_run <= 20'd10)
		else $error("device pull not tied to master edge");
	mst_low_a: assert property ($fell(mst_oe) |->
		m_run inside {[20'd99:20'd101], [20'd799:20'd801], [RSTL_CYC-1:RSTL_CYC+1]})
		else $error("master low time wrong");
	slot_len_a: assert property ($rose(mst_oe) && m_go |-> m_per >= 20'd1100)
		else $error("slot too short");
	rst_high_a: assert property ($rose(mst_oe) && last_m >= 20'd4000 |-> m_gap >= RESET_HIGH_INTERVAL_CYC)
		else $error("reset high interval cut");
	pup_wait_a: assert property ($rose(mst_oe) && !m_go |-> up_cnt >= PUP_CYC)
		else $error("master talked during power-up");
	// Main scenarios reached
	cover property ($fell(dev_oe) && pup);
	cover property ($rose(dev_oe) && !$past(line));
	cover property ($rose(mst_oe) && last_m >= 20'd4000);
endmodule : swsc_monitor

// *** bench/swsc_tb.sv ***
module swsc_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                mclk = 1'b0;
	logic                rst_n = 1'b0;
	logic                req_valid = 1'b0;
	swsc_pkg::swsc_op_e  req_op = swsc_pkg::OP_RESET;
	logic [7:0]          req_wdata = 8'h00;
	logic                req_crc_clr = 1'b0;
	logic                req_ready, rsp_valid, rsp_ok, cnt_loaded, dec_done;
	logic [7:0]          rsp_data;
	logic [16:0]         cnt_value;
	int                  failures = 0, tests_run = 0, cyc = 0, dec_cnt = 0;
	swsc_if bus ();
	swsc_dev swsc_dev_i (.mclk(mclk), .rst_n(rst_n), .bus(bus.dev), .cnt_value(cnt_value),
		.cnt_loaded(cnt_loaded), .dec_done(dec_done));
	// Power-up wait outlasts the device's power-up presence, else the first reset is missed
	swsc_mst #(.PUP_CYC(1500), .RSTL_CYC(4500), .RESET_HIGH_INTERVAL_CYC(1200)) swsc_mst_i (.mclk(mclk), .rst_n(rst_n),
		.bus(bus.mst), .req_valid(req_valid), .req_op(req_op), .req_wdata(req_wdata), .req_crc_clr(req_crc_clr),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ok(rsp_ok));
	swsc_monitor swsc_monitor_i (.mclk(mclk), .rst_n(rst_n),
		.dev_out(bus.dev_out), .dev_oe(bus.dev_oe), .mst_out(bus.mst_out), .mst_oe(bus.mst_oe), .line(bus.line));
	// Clock, decrement pulses and hang guard
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		dec_cnt += int'(dec_done === 1'b1);
		cyc++;
		if (cyc == 700000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Reflected CRC-16, LSB first, worked out on the bench side
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'hA001 : 16'h0000);
		return c;
	endfunction : crc8
	// One master request, held until taken, then wait for the answer
	task automatic op(input swsc_pkg::swsc_op_e o, input logic [7:0] d, input logic clr);
		while (req_ready !== 1'b1) @(negedge mclk);
		req_valid = 1'b1;
		req_op = o;
		req_wdata = d;
		req_crc_clr = clr;
		@(negedge mclk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1) @(negedge mclk);
	endtask : op
	// Full prefix and command; mode 0 master CRC, 1 bench CRC, 2 corrupted CRC
	task automatic cmd(input logic [7:0] sel, input logic [7:0] fn, input logic [23:0] par, input int np,
		input int mode);
		logic [15:0] c;
		op(swsc_pkg::OP_RESET, 8'h00, 1'b0);
		check("presence", 17'h1, {16'h0, rsp_ok});
		op(swsc_pkg::OP_WRITE, sel, 1'b0);
		op(swsc_pkg::OP_WRITE, swsc_pkg::CMD_START, 1'b0);
		op(swsc_pkg::OP_WRITE, fn, 1'b1);
		c = crc8(16'h0000, fn);
		for (int i = 0; i < np; i++) begin
			op(swsc_pkg::OP_WRITE, par[8*i+:8], 1'b0);
			c = crc8(c, par[8*i+:8]);
		end
		if (mode == 0) op(swsc_pkg::OP_WRCRC, 8'h00, 1'b0);
		else begin
			c = ~c ^ {15'h0, mode == 2};
			op(swsc_pkg::OP_WRITE, c[7:0], 1'b0);
			op(swsc_pkg::OP_WRITE, c[15:8], 1'b0);
		end
	endtask : cmd
	initial begin
		logic [16:0] v;
		int d0;
		void'($urandom(93770));
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		// Small start value so the count reaches zero in a short run
		v = 17'($urandom_range(2, 1));
		cmd(swsc_pkg::ROM_SKIP, swsc_pkg::FN_SET, {7'h0, v}, 3, 0);
		check("loaded", 17'h1, {16'h0, cnt_loaded});
		check("count after set", v, cnt_value);
		op(swsc_pkg::OP_READ, 8'h00, 1'b1);
		check("set result", {9'h0, swsc_pkg::RES_OK}, {9'h0, rsp_data});
		cmd(swsc_pkg::ROM_SKIP, swsc_pkg::FN_SET, 24'($urandom_range(131071, 0)), 3, 1);
		check("count after second set", v, cnt_value);
		op(swsc_pkg::OP_READ, 8'h00, 1'b1);
		check("second set result", {9'h0, swsc_pkg::RES_REFUSE}, {9'h0, rsp_data});
		d0 = dec_cnt;
		cmd(swsc_pkg::ROM_SKIP, swsc_pkg::FN_DEC, 24'h0, 0, 2);
		check("count after bad crc", v, cnt_value);
		op(swsc_pkg::OP_READ, 8'h00, 1'b1);
		check("bad crc result", {9'h0, swsc_pkg::RES_CRC}, {9'h0, rsp_data});
		// Resume right after a skip selects nothing, so the command start is refused
		cmd(swsc_pkg::ROM_RESUME, swsc_pkg::FN_DEC, 24'h0, 0, 1);
		check("count after unselected decrement", v, cnt_value);
		for (int k = 1; k <= v + 1; k++) begin
			cmd(swsc_pkg::ROM_SKIP, swsc_pkg::FN_DEC, 24'h0, 0, 1);
			check("count after decrement", (k > v) ? 17'h0 : v - 17'(k), cnt_value);
		end
		check("decrement pulses", 17'(v), 17'(dec_cnt - d0));
		for (int i = 0; i < 4; i++) begin
			op(swsc_pkg::OP_READ, 8'h00, i == 0);
			check("response byte", (i == 0) ? {9'h0, swsc_pkg::RES_FAIL} : 17'h0, {9'h0, rsp_data});
		end
		op(swsc_pkg::OP_RDCRC, 8'h00, 1'b0);
		check("response crc", 17'h1, {16'h0, rsp_ok});
		stop_test();
	end
endmodule : swsc_tb

// *** rtl/swsc_dev.sv ***
// Behaviour
// [R1] Counter start value settable once, then refused
// [R2] Decrement lowers by one, stops at zero
// [R3] Command start accepted only after selection
// [R4] CRC-16 on received and sent data
// [R5] Single master; device only answers
// [R6] Slot timing starts at master falling edge
// [R7] Power-up presence finishes within two milliseconds
// [R8] Master waits reset high interval before next
// [R9] Master waits power-up time before talking
// [R10] Eight-bit selection codes decoded
// [R11] Decrement at zero reports failure
module swsc_dev #(
	parameter logic [63:0] ROM_ID = 64'h0123_4567_89AB_CDEF // Arbitrary value
) (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	// Shared line
	swsc_if.dev                            bus,
	// Counter status
	output logic [swsc_pkg::CNT_W-1:0]     cnt_value,
	output logic                           cnt_loaded,
	output logic                           dec_done
);
	// Slot engine states
	typedef enum logic [4:0] {
		BS_IDLE  = 5'b00001,
		BS_SLOT  = 5'b00010,
		BS_RST   = 5'b00100,
		BS_PWAIT = 5'b01000,
		BS_PRES  = 5'b10000
	} swsc_dev_bs_e;

	// Protocol phases
	typedef enum logic [9:0] {
		P_NONE   = 10'b0000000001,
		P_ROM    = 10'b0000000010,
		P_MATCH  = 10'b0000000100,
		P_READID = 10'b0000001000,
		P_SEARCH = 10'b0000010000,
		P_START  = 10'b0000100000,
		P_CMD    = 10'b0001000000,
		P_PARAM  = 10'b0010000000,
		P_RXCRC  = 10'b0100000000,
		P_TX     = 10'b1000000000
	} swsc_dev_ph_e;

	// All state of the end
	typedef struct packed {
		logic                          s1;      // Sync stage one
		logic                          s2;      // Sync stage two
		logic                          prev;    // Previous synced level
		swsc_dev_bs_e                  bs;      // Slot engine
		swsc_pkg::swsc_tmr_t           tmr;     // Time since edge
		logic                          txs;     // Current slot is a read slot
		logic                          tbit;    // Bit sent in this slot
		swsc_dev_ph_e                  ph;      // Protocol phase
		logic [6:0]                    bcnt;    // Bit index in phase
		logic [1:0]                    sph;     // Search sub-slot
		logic [7:0]                    sh;      // Byte assembler
		logic [7:0]                    cmd;     // Function code
		logic [23:0]                   param;   // Set value
		logic [15:0]                   rxcrc;   // Received check word
		logic [15:0]                   crc;     // Running check
		logic [63:0]                   txbuf;   // Outgoing bits
		logic [swsc_pkg::CNT_W-1:0]    cnt;     // Counter value
		logic                          cnt_set; // Start value written
		logic                          resume;  // Selected earlier
		logic                          oe;      // Pulling the line low
		logic                          dec;     // Decrement pulse
	} swsc_dev_s;

	localparam swsc_dev_s DEV_RST = '{
		s1: 1'b1, s2: 1'b1, prev: 1'b1, bs: BS_PWAIT, tmr: '0,
		txs: 1'b0, tbit: 1'b1, ph: P_NONE, bcnt: 7'h00, sph: 2'h0,
		sh: 8'h00, cmd: 8'h00, param: 24'h000000, rxcrc: 16'h0000,
		crc: 16'h0000, txbuf: 64'h0, cnt: '0, cnt_set: 1'b0,
		resume: 1'b0, oe: 1'b0, dec: 1'b0};

	swsc_dev_s r_reg;   // Registered state
	swsc_dev_s r_next;  // Next state
	logic        rb;    // Sampled slot level
	logic [7:0]  byt;   // Byte with this bit
	logic        is_tx; // Phase sends bits
	logic        txb;   // Next bit to send
	logic [7:0]  res;   // Result code
	logic [31:0] resp;  // Result plus counter
	logic [15:0] rc;    // Check of response
	logic [15:0] rcv;   // Full received check

	// Which bit the coming slot carries
	always_comb begin
		is_tx = 1'b0;
		txb   = 1'b1;
		case (r_reg.ph)
			P_READID: begin
				is_tx = 1'b1;
				txb   = ROM_ID[r_reg.bcnt[5:0]];
			end
			P_SEARCH: begin
				is_tx = (r_reg.sph != 2'h2);
				txb   = ROM_ID[r_reg.bcnt[5:0]] ^ r_reg.sph[0];
			end
			P_TX: begin
				is_tx = 1'b1;
				txb   = r_reg.txbuf[0];
			end
			default: begin
				is_tx = 1'b0;
			end
		endcase
	end

	// Next-state logic
	always_comb begin
		r_next = r_reg;
		rb     = r_reg.s2;
		byt    = {r_reg.s2, r_reg.sh[7:1]};
		rcv    = {r_reg.s2, r_reg.rxcrc[15:1]};
		res    = swsc_pkg::RES_OK;
		resp   = 32'h00000000;
		rc     = swsc_pkg::CRC_INIT;
		// Two-stage synchroniser on the line
		r_next.s1   = bus.line;
		r_next.s2   = r_reg.s1;
		r_next.prev = r_reg.s2;
		r_next.dec  = 1'b0;
		if (r_reg.tmr != '1) begin
			r_next.tmr = r_reg.tmr + 1'b1;
		end
		case (r_reg.bs)
			BS_IDLE: begin
				// Never drives first; waits for the master edge
				if (r_reg.prev && !r_reg.s2) begin // [R5] [R6]
					r_next.bs   = BS_SLOT;
					r_next.tmr  = '0;
					r_next.txs  = is_tx;
					r_next.tbit = txb;
				end
			end
			BS_SLOT: begin
				if (r_reg.tmr == swsc_pkg::C_DEV_SAMPLE) begin // [R6]
					r_next.sh   = byt;
					r_next.bcnt = r_reg.bcnt + 7'h01;
					case (r_reg.ph)
						P_ROM: begin
							if (r_reg.bcnt == 7'h07) begin // [R10]
								r_next.bcnt = 7'h00;
								case (byt)
									swsc_pkg::ROM_SKIP: begin
										r_next.ph     = P_START;
										r_next.resume = 1'b0;
									end
									swsc_pkg::ROM_MATCH: begin
										r_next.ph = P_MATCH;
									end
									swsc_pkg::ROM_READ: begin
										r_next.ph     = P_READID;
										r_next.resume = 1'b0;
									end
									swsc_pkg::ROM_SEARCH: begin
										r_next.ph  = P_SEARCH;
										r_next.sph = 2'h0;
									end
									swsc_pkg::ROM_RESUME: begin
										r_next.ph = r_reg.resume ? P_START : P_NONE;
									end
									default: begin
										r_next.ph = P_NONE;
									end
								endcase
							end
						end
						P_MATCH: begin
							// Any mismatch drops out until the next reset
							if (rb != ROM_ID[r_reg.bcnt[5:0]]) begin // [R10]
								r_next.ph     = P_NONE;
								r_next.resume = 1'b0;
							end else if (r_reg.bcnt == swsc_pkg::ID_LAST) begin
								r_next.ph     = P_START;
								r_next.resume = 1'b1;
								r_next.bcnt   = 7'h00;
							end
						end
						P_READID: begin
							if (r_reg.bcnt == swsc_pkg::ID_LAST) begin
								r_next.ph   = P_START;
								r_next.bcnt = 7'h00;
							end
						end
						P_SEARCH: begin
							// Bit, complement, then the master's choice
							r_next.bcnt = r_reg.bcnt;
							r_next.sph  = r_reg.sph + 2'h1;
							if (r_reg.sph == 2'h2) begin // [R10]
								r_next.sph  = 2'h0;
								r_next.bcnt = r_reg.bcnt + 7'h01;
								if (rb != ROM_ID[r_reg.bcnt[5:0]]) begin
									r_next.ph     = P_NONE;
									r_next.resume = 1'b0;
								end else if (r_reg.bcnt == swsc_pkg::ID_LAST) begin
									r_next.ph     = P_START;
									r_next.resume = 1'b1;
									r_next.bcnt   = 7'h00;
								end
							end
						end
						P_START: begin
							// Only reachable after a good selection
							if (r_reg.bcnt == 7'h07) begin // [R3]
								r_next.bcnt = 7'h00;
								r_next.crc  = swsc_pkg::CRC_INIT;
								r_next.ph   = (byt == swsc_pkg::CMD_START) ? P_CMD : P_NONE;
							end
						end
						P_CMD: begin
							r_next.crc = swsc_pkg::swsc_crc_bit(r_reg.crc, rb); // [R4]
							if (r_reg.bcnt == 7'h07) begin
								r_next.bcnt = 7'h00;
								r_next.cmd  = byt;
								case (byt)
									swsc_pkg::FN_SET: begin
										r_next.ph = P_PARAM;
									end
									swsc_pkg::FN_DEC, swsc_pkg::FN_READ: begin
										r_next.ph = P_RXCRC;
									end
									default: begin
										r_next.ph = P_NONE;
									end
								endcase
							end
						end
						P_PARAM: begin
							r_next.crc   = swsc_pkg::swsc_crc_bit(r_reg.crc, rb); // [R4]
							r_next.param = {rb, r_reg.param[23:1]};
							if (r_reg.bcnt == swsc_pkg::PARAM_LAST) begin
								r_next.ph   = P_RXCRC;
								r_next.bcnt = 7'h00;
							end
						end
						P_RXCRC: begin
							r_next.rxcrc = rcv;
							if (r_reg.bcnt == swsc_pkg::CRC_LAST) begin
								r_next.ph   = P_TX;
								r_next.bcnt = 7'h00;
								// A corrupted frame changes nothing
								if (rcv != ~r_reg.crc) begin // [R4]
									res = swsc_pkg::RES_CRC;
								end else if (r_reg.cmd == swsc_pkg::FN_SET) begin
									if (r_reg.cnt_set) begin
										res = swsc_pkg::RES_REFUSE; // [R1]
									end else begin
										r_next.cnt     = r_reg.param[swsc_pkg::CNT_W-1:0]; // [R1]
										r_next.cnt_set = 1'b1;
									end
								end else if (r_reg.cmd == swsc_pkg::FN_DEC) begin
									if (!r_reg.cnt_set || r_reg.cnt == '0) begin
										res = swsc_pkg::RES_FAIL; // [R2] [R11]
									end else begin
										r_next.cnt = r_reg.cnt - 1'b1; // [R2]
										r_next.dec = 1'b1;
									end
								end
								// Answer carries its own check word
								resp = {7'h00, r_next.cnt, res};
								for (int i = 0; i < 32; i++) begin
									rc = swsc_pkg::swsc_crc_bit(rc, resp[i]); // [R4]
								end
								r_next.txbuf = {16'h0000, ~rc, resp};
							end
						end
						P_TX: begin
							r_next.txbuf = {1'b0, r_reg.txbuf[63:1]};
							if (r_reg.bcnt == swsc_pkg::RESP_LAST) begin
								r_next.ph = P_NONE;
							end
						end
						default: begin
							r_next.bcnt = r_reg.bcnt;
						end
					endcase
				end
				// Long low is a reset; release ends the slot
				if (!r_reg.s2 && r_reg.tmr >= swsc_pkg::C_DEV_RSTDET) begin
					r_next.bs = BS_RST;
				end else if (r_reg.s2 && r_reg.tmr > swsc_pkg::C_DEV_SAMPLE) begin
					r_next.bs = BS_IDLE;
				end
			end
			BS_RST: begin
				if (r_reg.s2) begin
					r_next.bs   = BS_PWAIT;
					r_next.tmr  = '0;
					r_next.ph   = P_ROM;
					r_next.bcnt = 7'h00;
				end
			end
			BS_PWAIT: begin
				// Also the power-up path, so that pulse ends in microseconds
				if (r_reg.tmr == swsc_pkg::C_DEV_PWAIT) begin // [R7]
					r_next.bs  = BS_PRES;
					r_next.tmr = '0;
				end
			end
			BS_PRES: begin
				if (r_reg.tmr == swsc_pkg::C_DEV_PRES) begin // [R7]
					r_next.bs = BS_IDLE;
				end
			end
			default: begin
				r_next.bs = BS_IDLE;
			end
		endcase
		// Pull low for presence or a zero read bit
		r_next.oe = (r_next.bs == BS_PRES) ||
			(r_next.bs == BS_SLOT && r_next.txs && !r_next.tbit &&
			r_next.tmr < swsc_pkg::C_DEV_RDHOLD);
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= DEV_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from state
	assign bus.dev_out = 1'b0;
	assign bus.dev_oe  = r_reg.oe;
	assign cnt_value   = r_reg.cnt;
	assign cnt_loaded  = r_reg.cnt_set;
	assign dec_done    = r_reg.dec;
endmodule : swsc_dev

// *** rtl/swsc_if.sv ***
// Shared open-drain line; either end pulls it low
interface swsc_if;
	logic dev_out;
	logic dev_oe;
	logic mst_out;
	logic mst_oe;
	logic line;
	// Wired-AND with the pullup
	assign line = !(dev_oe && !dev_out) && !(mst_oe && !mst_out);
	modport dev (input line, output dev_out, output dev_oe);
	modport mst (input line, output mst_out, output mst_oe);
endinterface : swsc_if

// *** rtl/swsc_mst.sv ***
module swsc_mst #(
	parameter int PUP_CYC  = swsc_pkg::PUP_CYC_DEF,  // Power-up wait
	parameter int RSTL_CYC = swsc_pkg::RSTL_CYC_DEF, // Reset low
	parameter int RESET_HIGH_INTERVAL_CYC = swsc_pkg::RESET_HIGH_INTERVAL_CYC_DEF  // Reset high interval
) (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rst_n,
	// Shared line
	swsc_if.mst                     bus,
	// Request
	input  wire logic               req_valid,
	input  wire swsc_pkg::swsc_op_e req_op,
	input  wire logic [7:0]         req_wdata,
	input  wire logic               req_crc_clr,
	output logic                    req_ready,
	// Answer
	output logic                    rsp_valid,
	output logic [7:0]              rsp_data,
	output logic                    rsp_ok
);
	// Master states
	typedef enum logic [4:0] {
		M_PUP  = 5'b00001,
		M_IDLE = 5'b00010,
		M_RSTL = 5'b00100,
		M_RESET_HIGH_INTERVAL = 5'b01000,
		M_SLOT = 5'b10000
	} swsc_mst_st_e;

	// All state of the end
	typedef struct packed {
		logic                s1;    // Sync stage one
		logic                s2;    // Sync stage two
		swsc_mst_st_e        st;    // State
		swsc_pkg::swsc_tmr_t tmr;   // Time in state or slot
		swsc_pkg::swsc_op_e  op;    // Current operation
		logic [15:0]         sh;    // Bits out or in
		logic [4:0]          nb;    // Bits left
		logic                smp;   // Sampled read bit
		logic [15:0]         crc;   // Running check
		logic                oe;    // Pulling low
		logic                ready; // Idle for requests
		logic                rv;    // Answer pulse
		logic [7:0]          rdata; // Answer byte
		logic                rok;   // Presence or check good
	} swsc_mst_s;

	localparam swsc_mst_s MST_RST = '{
		s1: 1'b1, s2: 1'b1, st: M_PUP, tmr: '0, op: swsc_pkg::OP_RESET,
		sh: 16'h0000, nb: 5'h00, smp: 1'b1, crc: 16'h0000, oe: 1'b0,
		ready: 1'b0, rv: 1'b0, rdata: 8'h00, rok: 1'b0};

	swsc_mst_s           r_reg;  // Registered state
	swsc_mst_s           r_next; // Next state
	logic [15:0]         cbase;  // Check after optional clear
	logic [15:0]         shn;    // Shifted bits at slot end
	swsc_pkg::swsc_tmr_t lowt;   // Low time of the slot

	// Next-state logic
	always_comb begin
		r_next = r_reg;
		cbase  = req_crc_clr ? swsc_pkg::CRC_INIT : r_reg.crc;
		shn    = 16'h0000;
		lowt   = swsc_pkg::C_RL;
		r_next.s1 = bus.line;
		r_next.s2 = r_reg.s1;
		r_next.rv = 1'b0;
		if (r_reg.tmr != '1) begin
			r_next.tmr = r_reg.tmr + 1'b1;
		end
		case (r_reg.st)
			M_PUP: begin
				// Stay off the line until the device has powered up
				if (r_reg.tmr == swsc_pkg::swsc_tmr_t'(PUP_CYC - 1)) begin // [R9]
					r_next.st    = M_IDLE;
					r_next.ready = 1'b1;
				end
			end
			M_IDLE: begin
				// Sole initiator of every transaction
				if (req_valid) begin // [R5]
					r_next.ready = 1'b0;
					r_next.op    = req_op;
					r_next.tmr   = '0;
					r_next.crc   = cbase;
					r_next.st    = M_SLOT;
					r_next.sh    = 16'h0000;
					r_next.nb    = 5'h08;
					case (req_op)
						swsc_pkg::OP_RESET: begin
							r_next.st = M_RSTL; // [R3]
						end
						swsc_pkg::OP_WRITE: begin
							r_next.sh = {8'h00, req_wdata};
						end
						swsc_pkg::OP_READ: begin
							r_next.nb = 5'h08;
						end
						swsc_pkg::OP_WRCRC: begin
							r_next.sh = ~cbase; // [R4]
							r_next.nb = 5'h10;
						end
						swsc_pkg::OP_RDCRC: begin
							r_next.nb = 5'h10;
						end
						default: begin
							// Unknown operation answered at once
							r_next.st    = M_IDLE;
							r_next.ready = 1'b1;
							r_next.rv    = 1'b1;
							r_next.rok   = 1'b0;
						end
					endcase
				end
			end
			M_RSTL: begin
				if (r_reg.tmr == swsc_pkg::swsc_tmr_t'(RSTL_CYC - 1)) begin
					r_next.st  = M_RESET_HIGH_INTERVAL;
					r_next.tmr = '0;
					r_next.rok = 1'b0;
				end
			end
			M_RESET_HIGH_INTERVAL: begin
				if (r_reg.tmr == swsc_pkg::C_MSP) begin
					r_next.rok = !r_reg.s2;
				end
				// Nothing new until the reset high interval is over
				if (r_reg.tmr == swsc_pkg::swsc_tmr_t'(RESET_HIGH_INTERVAL_CYC - 1)) begin // [R8]
					r_next.st    = M_IDLE;
					r_next.ready = 1'b1;
					r_next.rv    = 1'b1;
					r_next.rdata = 8'h00;
				end
			end
			M_SLOT: begin
				if (r_reg.tmr == swsc_pkg::C_MSR) begin
					r_next.smp = r_reg.s2;
				end
				if (r_reg.tmr == swsc_pkg::C_SLOT - 1'b1) begin
					r_next.tmr = '0;
					r_next.nb  = r_reg.nb - 5'h01;
					if (r_reg.op == swsc_pkg::OP_READ || r_reg.op == swsc_pkg::OP_RDCRC) begin
						shn = {r_reg.smp, r_reg.sh[15:1]};
					end else begin
						shn = {1'b0, r_reg.sh[15:1]};
					end
					r_next.sh = shn;
					if (r_reg.op == swsc_pkg::OP_WRITE) begin
						r_next.crc = swsc_pkg::swsc_crc_bit(r_reg.crc, r_reg.sh[0]); // [R4]
					end else if (r_reg.op == swsc_pkg::OP_READ) begin
						r_next.crc = swsc_pkg::swsc_crc_bit(r_reg.crc, r_reg.smp); // [R4]
					end
					if (r_reg.nb == 5'h01) begin
						r_next.st    = M_IDLE;
						r_next.ready = 1'b1;
						r_next.rv    = 1'b1;
						r_next.rdata = shn[15:8];
						r_next.rok   = (r_reg.op != swsc_pkg::OP_RDCRC) || (shn == ~r_reg.crc); // [R4]
					end
				end
			end
			default: begin
				r_next.st = M_IDLE;
			end
		endcase
		// Every slot opens with our falling edge
		if (r_next.op == swsc_pkg::OP_WRITE || r_next.op == swsc_pkg::OP_WRCRC) begin
			lowt = r_next.sh[0] ? swsc_pkg::C_W1L : swsc_pkg::C_W0L;
		end
		r_next.oe = (r_next.st == M_RSTL) || (r_next.st == M_SLOT && r_next.tmr < lowt); // [R6]
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= MST_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from state
	assign bus.mst_out = 1'b0;
	assign bus.mst_oe  = r_reg.oe;
	assign req_ready   = r_reg.ready;
	assign rsp_valid   = r_reg.rv;
	assign rsp_data    = r_reg.rdata;
	assign rsp_ok      = r_reg.rok;
endmodule : swsc_mst

// *** rtl/swsc_pkg.sv ***
package swsc_pkg;
	// Clock period
	localparam int CLK_NS = 10;
	// Device timing: slot times from the seen falling edge, presence wait from the seen release, presence from the end of that wait
	localparam int T_DEV_SAMPLE_NS = 3500;
	localparam int T_DEV_RDHOLD_NS = 3000;
	localparam int T_DEV_RSTDET_NS = 40000;
	localparam int T_DEV_PWAIT_NS  = 2000;
	localparam int T_DEV_PRES_NS   = 8000;
	// Master timing
	localparam int T_PUP_WAIT_NS = 2000000;
	localparam int T_RSTL_NS     = 54000;
	localparam int T_RESET_HIGH_INTERVAL_NS     = 48000;
	localparam int T_MSP_NS      = 8500;
	localparam int T_W0L_NS      = 8000;
	localparam int T_W1L_NS      = 1000;
	localparam int T_RL_NS       = 1000;
	localparam int T_MSR_NS      = 1500;
	localparam int T_SLOT_NS     = 13000;
	// Timer type and cycle counts (least times round up)
	localparam int TW = 20;
	typedef logic [TW-1:0] swsc_tmr_t;
	localparam swsc_tmr_t C_DEV_SAMPLE = swsc_tmr_t'((T_DEV_SAMPLE_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_DEV_RDHOLD = swsc_tmr_t'((T_DEV_RDHOLD_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_DEV_RSTDET = swsc_tmr_t'((T_DEV_RSTDET_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_DEV_PWAIT  = swsc_tmr_t'((T_DEV_PWAIT_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_DEV_PRES   = swsc_tmr_t'((T_DEV_PRES_NS + CLK_NS - 1) / CLK_NS);
	localparam int        PUP_CYC_DEF  = (T_PUP_WAIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int        RSTL_CYC_DEF = (T_RSTL_NS + CLK_NS - 1) / CLK_NS;
	localparam int        RESET_HIGH_INTERVAL_CYC_DEF = (T_RESET_HIGH_INTERVAL_NS + CLK_NS - 1) / CLK_NS;
	localparam swsc_tmr_t C_MSP        = swsc_tmr_t'((T_MSP_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_W0L        = swsc_tmr_t'((T_W0L_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_W1L        = swsc_tmr_t'((T_W1L_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_RL         = swsc_tmr_t'((T_RL_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_MSR        = swsc_tmr_t'((T_MSR_NS + CLK_NS - 1) / CLK_NS);
	localparam swsc_tmr_t C_SLOT       = swsc_tmr_t'((T_SLOT_NS + CLK_NS - 1) / CLK_NS);
	// Selection codes
	localparam logic [7:0] ROM_SEARCH = 8'hF0;
	localparam logic [7:0] ROM_READ   = 8'h33;
	localparam logic [7:0] ROM_MATCH  = 8'h55;
	localparam logic [7:0] ROM_SKIP   = 8'hCC;
	localparam logic [7:0] ROM_RESUME = 8'hA5;
	// Command start, function codes and results
	localparam logic [7:0] CMD_START = 8'h66;
	localparam logic [7:0] FN_SET    = 8'h11;
	localparam logic [7:0] FN_DEC    = 8'h22;
	localparam logic [7:0] FN_READ   = 8'h44;
	localparam logic [7:0] RES_OK    = 8'hAA;
	localparam logic [7:0] RES_REFUSE = 8'h55;
	localparam logic [7:0] RES_FAIL  = 8'h33;
	localparam logic [7:0] RES_CRC   = 8'hEE;
	// Widths, bit-index limits and CRC constants
	localparam int         CNT_W      = 17;
	localparam logic [6:0] ID_LAST    = 7'h3F;
	localparam logic [6:0] PARAM_LAST = 7'h17;
	localparam logic [6:0] CRC_LAST   = 7'h0F;
	localparam logic [6:0] RESP_LAST  = 7'h2F;
	localparam logic [15:0] CRC_POLY  = 16'hA001;
	localparam logic [15:0] CRC_INIT  = 16'h0000;
	// Master operations
	typedef enum logic [2:0] {
		OP_RESET = 3'h0,
		OP_WRITE = 3'h1,
		OP_READ  = 3'h2,
		OP_WRCRC = 3'h3,
		OP_RDCRC = 3'h4
	} swsc_op_e;

	// One bit of reflected CRC-16, LSB first
	function automatic logic [15:0] swsc_crc_bit(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[0] ^ b;
		swsc_crc_bit = (c >> 1) ^ (fb ? CRC_POLY : 16'h0000);
	endfunction : swsc_crc_bit
endpackage : swsc_pkg
